// *** bench/pps_core_props.sv ***
/* pps_core port checker, bound into every pps_core instance.
   assumes pclk clocks all ports and presetn resets asynchronously. */
module pps_core_props
	import pps_pkg::*;
(
	// clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// apb
	input wire logic                  pwrite,
	input wire logic [PPS_ADDR_W-1:0] paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	// sequencer
	input wire pps_dec_s              dec,
	input wire logic                  irq_req,
	input wire logic                  irq_ack,
	input wire pps_fetch_s            fetch,
	input wire logic [PPS_PHASES-1:0] instruction_phases,
	input wire logic                  exec_valid,
	input wire logic [PPS_PC_W-1:0]   exec_addr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rot; $past(presetn)
		|-> instruction_phases == {$past(instruction_phases[2:0]), $past(instruction_phases[3])}; endproperty
	a_rot: assert property (p_rot) else $error("phase rotation broken");
	property p_t1; fetch.strobe |-> instruction_phases == 4'b0001; endproperty
	a_t1: assert property (p_t1) else $error("fetch outside first phase");
	property p_hold; instruction_phases != 4'b0001 |-> $stable(exec_addr); endproperty
	a_hold: assert property (p_hold) else $error("exec address moved mid cycle");
	property p_jmp; instruction_phases == 4'b0100 && exec_valid && dec.op == PPS_OP_JUMP
		|-> ##2 fetch.strobe && !exec_valid && fetch.addr[12:0] == $past(dec.target, 2); endproperty
	a_jmp: assert property (p_jmp) else $error("jump not flushed to target");
	property p_rst; $rose(presetn) |=> fetch.strobe && fetch.addr == PPS_PC_RESET; endproperty
	a_rst: assert property (p_rst) else $error("first fetch not at zero");
	property p_rbh; pready && !pwrite && paddr == PPS_OFS_PC_READBACK_HIGH |-> prdata[31:6] == 26'h0; endproperty
	a_rbh: assert property (p_rbh) else $error("readback high upper bits set");
	property p_sp; pready && !pwrite && paddr == PPS_OFS_RETURN_STACK_INDEX |-> prdata[31:4] == 28'h0; endproperty
	a_sp: assert property (p_sp) else $error("stack index upper bits set");
	property p_ack; irq_ack |-> instruction_phases == 4'b1000 && $past(irq_req); endproperty
	a_ack: assert property (p_ack) else $error("acknowledge without request");
endmodule : pps_core_props

bind pps_core pps_core_props u_props (.pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .dec(dec), .irq_req(irq_req), .irq_ack(irq_ack), .fetch(fetch),
	.instruction_phases(instruction_phases), .exec_valid(exec_valid), .exec_addr(exec_addr));

// *** bench/pps_core_tb.sv ***
/* self-checking bench of pps_core: apb accesses and decoded ops.
   assumes the bound port checker and one pclk domain. */
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module pps_core_tb
	import pps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_req = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, irq_ack, exec_valid, er;
	logic [3:0]  instruction_phases;
	logic [13:0] irq_vector = 14'h0300, exec_addr;
	pps_dec_s    dec = '{PPS_OP_SEQ, 13'h0000};
	pps_fetch_s  fetch;
	int          err_count = 0, checks_done = 0, n;

	pps_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.dec, .irq_req, .irq_vector, .irq_ack, .fetch, .instruction_phases, .exec_valid, .exec_addr);

	initial forever #5 pclk = ~pclk;
	// a hang costs a mismatch, far beyond the ~400 cycles needed
	initial begin
		#200000;
		err_count++;
		conclude();
	end

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// op is consumed at the edge leaving the third phase
	task step(input pps_op_e op, input logic [12:0] t);
		dec <= '{op, t};
		do @(posedge pclk); while (!(instruction_phases === 4'b0100 && exec_valid === 1'b1));
		dec <= '{PPS_OP_SEQ, 13'h0000};
	endtask : step
	task t1;
		do @(posedge pclk); while (instruction_phases !== 4'b0001);
	endtask : t1
	task chk_jump(input logic [13:0] a);
		t1();
		`CHK(exec_valid, 1'b0);
		t1();
		`CHK(exec_addr, a);
	endtask : chk_jump
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, PPS_OFS_RETURN_STACK_INDEX, 32'h0);
		`CHK(rd, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		`CHK(er, 1'b1);
		$display("test reset done");
		step(PPS_OP_JUMP, 13'h0123);
		chk_jump(14'h0123);
		step(PPS_OP_CALL, 13'h0500);
		chk_jump(14'h0500);
		step(PPS_OP_RET, 13'h0000);
		chk_jump(14'h0124);
		step(PPS_OP_SKIP, 13'h0000);
		chk_jump(14'h0126);
		t1();
		`CHK(exec_addr, 14'h0127);
		apb(1'b0, PPS_OFS_PC_READBACK_LOW, 32'h0);
		`CHK(rd, 32'h27);
		$display("test flow done");
		apb(1'b1, PPS_OFS_CODE_BANK_CTRL, 32'h1);
		step(PPS_OP_JUMP, 13'h0045);
		chk_jump(14'h2045);
		// buffer still holds the page latched before the bank switch
		apb(1'b0, PPS_OFS_PC_READBACK_HIGH, 32'h0);
		`CHK(rd, 32'h01);
		apb(1'b0, PPS_OFS_PC_READBACK_LOW, 32'h0);
		apb(1'b0, PPS_OFS_PC_READBACK_HIGH, 32'h0);
		`CHK(rd, 32'h20);
		apb(1'b1, PPS_OFS_PC_LOW_BYTE, 32'h80);
		do t1(); while (exec_valid !== 1'b0);
		t1();
		`CHK(exec_addr, 14'h2080);
		$display("test bank done");
		for (n = 1; n <= 16; n++) begin
			step(PPS_OP_CALL, 13'h0600);
			apb(1'b0, PPS_OFS_RETURN_STACK_INDEX, 32'h0);
			`CHK(rd, {28'h0, 4'(n)});
		end
		// a seventeenth call from a new address replaces the oldest entry
		step(PPS_OP_JUMP, 13'h0700);
		chk_jump(14'h2700);
		step(PPS_OP_CALL, 13'h0600);
		chk_jump(14'h2600);
		apb(1'b0, PPS_OFS_RETURN_STACK_INDEX, 32'h0);
		`CHK(rd, 32'h1);
		irq_req <= 1'b1;
		n = 0;
		repeat (12) begin
			@(posedge pclk);
			if (irq_ack !== 1'b0) n++;
		end
		`CHK(n, 0);
		step(PPS_OP_RET, 13'h0000);
		chk_jump(14'h2701);
		n = 0;
		while (irq_ack !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		`CHK(irq_ack, 1'b1);
		irq_req <= 1'b0;
		for (n = 1; n <= 16; n++) begin
			step(n[0] ? PPS_OP_RET : PPS_OP_INTERRUPT_RETURN_OP, 13'h0000);
			apb(1'b0, PPS_OFS_RETURN_STACK_INDEX, 32'h0);
			`CHK(rd, {28'h0, 4'(1 - n)});
		end
		$display("test stack done");
		conclude();
	end
endmodule : pps_core_tb

// *** logic/pps_core.sv ***
/*
 * instruction sequencing core: four-phase instruction cycle, program
 * counter with bank select, flush of prefetched instructions, program
 * counter read-back and a 16-level return stack, with an APB slave.
 * assumes decode, interrupt request and vector come from logic on pclk.
 */
// The APB interface to the registers and the register offsets were decided locally.
// Functional notes
// RL1: four phases form one instruction cycle
// RL2: fetch and counter advance at first phase
// RL3: fetch overlaps execute, one per cycle
// RL4: flow change flushes prefetch, one extra cycle
// RL5: counter increments, or loads target address
// RL6: bank select bit supplies upper address
// RL7: taken skip discards prefetch, dummy cycle
// RL8: low byte write jumps in page
// RL9: readback low read latches high buffer
// RL10: software reads low before high
// RL11: high readback bits 5..0, upper zero
// RL12: sixteen-level stack, not software accessible
// RL13: call/interrupt push, returns pop
// RL14: stack index zero after reset
// RL15: stack full withholds interrupt acknowledge
// RL16: call on full stack overwrites oldest
// RL17: stack index read-only, bits 3..0
// RL18: calls increment index modulo sixteen
// RL19: returns decrement index modulo sixteen
// RL20: execution starts at address zero
// RL21: fourteen-bit counter, bank bit on top
module pps_core
	import pps_pkg::*;
(
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PPS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// decode and interrupt side
	input  wire pps_dec_s              dec,
	input  wire logic                  irq_req,
	input  wire logic [PPS_PC_W-1:0]   irq_vector,
	output logic                       irq_ack,
	// fetch and execute side
	output pps_fetch_s                 fetch,
	output logic      [PPS_PHASES-1:0] instruction_phases,
	output logic                       exec_valid,
	output logic      [PPS_PC_W-1:0]   exec_addr
);

	typedef struct packed {
		logic [PPS_PHASES-1:0]               phase;
		logic [PPS_PC_W-1:0]                 pc;
		pps_fetch_s                          fetch;
		logic [PPS_PC_W-1:0]                 exec_addr;
		logic                                exec_valid;
		logic                                flush;
		logic [PPS_DEPTH-1:0][PPS_PC_W-1:0]  stack;
		logic [PPS_SP_W-1:0]                 sp;
		logic [PPS_DEPTH_W-1:0]              depth;
		logic                                irq_ack;
		logic                                code_bank_select;
		logic                                pcl_pend;
		logic [7:0]                          pcl_data;
		logic [7:0]                          rbh_buf;
		logic                                pready;
		logic                                pslverr;
		logic [31:0]                         prdata;
	} pps_state_s;

	pps_state_s s_reg;
	pps_state_s s_next;

	always_comb begin
		logic                acc;
		logic                done;
		logic [PPS_SP_W-1:0] sp_dec;
		logic [7:0]          rd_byte;
		logic                rd_ok;
		acc     = psel & penable;
		done    = acc & s_reg.pready;
		sp_dec  = s_reg.sp - 4'h1;
		rd_byte = PPS_BYTE_RESET;
		rd_ok   = 1'b1;

		s_next              = s_reg;
		s_next.fetch.strobe = 1'b0;
		s_next.irq_ack      = 1'b0;

		// one-hot rotation through the four phases, one per pclk
		s_next.phase = {s_reg.phase[PPS_PHASES-2:0], s_reg.phase[PPS_PHASES-1]}; // RL1

		// end of third phase: resolve the executing instruction
		if (s_reg.phase[2] && s_reg.exec_valid) begin
			case (dec.op)
				PPS_OP_JUMP, PPS_OP_CALL: begin
					if (dec.op == PPS_OP_CALL) begin
						// return address is the flushed prefetch address
						s_next.stack[s_reg.sp] = s_reg.fetch.addr; // RL13 RL16
						s_next.sp              = s_reg.sp + 4'h1; // RL18
						if (s_reg.depth != PPS_DEPTH_FULL) begin
							s_next.depth = s_reg.depth + 5'h01;
						end
					end
					s_next.pc    = {s_reg.code_bank_select, dec.target}; // RL5 RL6 RL21
					s_next.flush = 1'b1; // RL4
				end
				PPS_OP_RET, PPS_OP_INTERRUPT_RETURN_OP: begin
					s_next.pc    = s_reg.stack[sp_dec]; // RL13
					s_next.sp    = sp_dec; // RL19
					s_next.flush = 1'b1; // RL4
					if (s_reg.depth != PPS_DEPTH_RESET) begin
						s_next.depth = s_reg.depth - 5'h01;
					end
				end
				PPS_OP_SKIP: begin
					// counter already points past the discarded instruction
					s_next.flush = 1'b1; // RL7
				end
				default: begin
					// interrupts are only taken between plain instructions
					if (irq_req && s_reg.depth != PPS_DEPTH_FULL) begin // RL15
						s_next.stack[s_reg.sp] = s_reg.fetch.addr; // RL13
						s_next.sp              = s_reg.sp + 4'h1; // RL18
						s_next.depth           = s_reg.depth + 5'h01;
						s_next.pc              = irq_vector; // RL5
						s_next.flush           = 1'b1; // RL4
						s_next.irq_ack         = 1'b1;
					end else if (s_reg.pcl_pend) begin
						s_next.pc[7:0]  = s_reg.pcl_data; // RL8
						s_next.pcl_pend = 1'b0;
						s_next.flush    = 1'b1; // RL8
					end
				end
			endcase
		end

		// end of fourth phase: fetch at the first phase of the next cycle
		if (s_reg.phase[PPS_PHASES-1]) begin
			s_next.fetch.strobe = 1'b1; // RL2
			s_next.fetch.addr   = s_reg.pc; // RL2 RL3
			s_next.pc           = s_reg.pc + 14'h0001; // RL5
			s_next.exec_addr    = s_reg.fetch.addr; // RL3
			s_next.exec_valid   = ~s_reg.flush; // RL4 RL7
			s_next.flush        = 1'b0;
		end

		// apb: one wait state, answer prepared in the first access cycle
		s_next.pready = acc & ~s_reg.pready;
		if (acc && !s_reg.pready) begin
			if (paddr == PPS_OFS_PC_LOW_BYTE) begin
				rd_byte = s_reg.exec_addr[7:0];
			end else if (paddr == PPS_OFS_PC_READBACK_LOW) begin
				rd_byte = s_reg.exec_addr[7:0]; // RL9
				// latched with the low byte so the pair stays consistent
				if (!pwrite) begin
					s_next.rbh_buf = {2'b00, s_reg.exec_addr[PPS_PC_W-1:8]}; // RL9 RL10
				end
			end else if (paddr == PPS_OFS_PC_READBACK_HIGH) begin
				rd_byte = {2'b00, s_reg.rbh_buf[PPS_RBH_MSB:0]}; // RL11
			end else if (paddr == PPS_OFS_RETURN_STACK_INDEX) begin
				rd_byte = {4'h0, s_reg.sp}; // RL17
			end else if (paddr == PPS_OFS_CODE_BANK_CTRL) begin
				rd_byte = {7'h00, s_reg.code_bank_select};
			end else begin
				rd_ok = 1'b0;
			end
			s_next.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			s_next.pslverr = ~rd_ok;
		end else if (!acc) begin
			s_next.prdata  = 32'h0000_0000;
			s_next.pslverr = 1'b0;
		end

		// writes take effect only at the completing edge
		if (done && pwrite) begin
			if (paddr == PPS_OFS_PC_LOW_BYTE) begin
				s_next.pcl_pend = 1'b1; // RL8
				s_next.pcl_data = pwdata[7:0];
			end else if (paddr == PPS_OFS_CODE_BANK_CTRL) begin
				s_next.code_bank_select = pwdata[PPS_BANK_BIT]; // RL6
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg                  <= '0;
			s_reg.phase            <= PPS_PHASE_RESET;
			s_reg.pc               <= PPS_PC_RESET; // RL20
			s_reg.fetch.addr       <= PPS_PC_RESET;
			s_reg.exec_addr        <= PPS_PC_RESET;
			s_reg.flush            <= 1'b1;
			s_reg.sp               <= PPS_SP_RESET; // RL14
			s_reg.depth            <= PPS_DEPTH_RESET;
			s_reg.code_bank_select <= PPS_BANK_RESET;
			s_reg.pcl_data         <= PPS_BYTE_RESET;
			s_reg.rbh_buf          <= PPS_BYTE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// the stack array has no path to the bus at all
	assign prdata             = s_reg.prdata; // RL12
	assign pready             = s_reg.pready;
	assign pslverr            = s_reg.pslverr;
	assign irq_ack            = s_reg.irq_ack;
	assign fetch              = s_reg.fetch;
	assign instruction_phases = s_reg.phase;
	assign exec_valid         = s_reg.exec_valid;
	assign exec_addr          = s_reg.exec_addr;

endmodule : pps_core

// *** logic/pps_pkg.sv ***
/*
 * shared constants and types of the instruction sequencing core:
 * register offsets, field positions, reset values and the carriers
 * of the decode input and the fetch output.
 * assumes a 32-bit APB bus with byte addresses of 12 bits.
 */
package pps_pkg;

	// widths
	localparam int PPS_PC_W     = 14;
	localparam int PPS_INBANK_W = 13;
	localparam int PPS_SP_W     = 4;
	localparam int PPS_DEPTH    = 16;
	localparam int PPS_DEPTH_W  = 5;
	localparam int PPS_ADDR_W   = 12;
	localparam int PPS_PHASES   = 4;

	// register byte offsets
	localparam logic [11:0] PPS_OFS_PC_LOW_BYTE        = 12'h000;
	localparam logic [11:0] PPS_OFS_PC_READBACK_LOW    = 12'h004;
	localparam logic [11:0] PPS_OFS_PC_READBACK_HIGH   = 12'h008;
	localparam logic [11:0] PPS_OFS_RETURN_STACK_INDEX = 12'h00c;
	localparam logic [11:0] PPS_OFS_CODE_BANK_CTRL     = 12'h010;

	// field positions
	localparam int PPS_BANK_BIT  = 0;
	localparam int PPS_RBH_MSB   = 5;
	localparam int PPS_SP_MSB    = 3;

	// reset values
	localparam logic [13:0] PPS_PC_RESET    = 14'h0000;
	localparam logic [3:0]  PPS_SP_RESET    = 4'h0;
	localparam logic [4:0]  PPS_DEPTH_RESET = 5'h00;
	localparam logic        PPS_BANK_RESET  = 1'b0;
	localparam logic [7:0]  PPS_BYTE_RESET  = 8'h00;
	localparam logic [3:0]  PPS_PHASE_RESET = 4'h8;
	localparam logic [4:0]  PPS_DEPTH_FULL  = 5'h10;

	typedef enum logic [2:0] {
		PPS_OP_SEQ,
		PPS_OP_JUMP,
		PPS_OP_CALL,
		PPS_OP_RET,
		PPS_OP_INTERRUPT_RETURN_OP,
		PPS_OP_SKIP
	} pps_op_e;

	// decode result of the instruction now executing
	typedef struct packed {
		pps_op_e     op;
		logic [12:0] target;
	} pps_dec_s;

	// fetch request towards program memory
	typedef struct packed {
		logic        strobe;
		logic [13:0] addr;
	} pps_fetch_s;

endpackage : pps_pkg
